// [hw/ess_pkg.sv]
// Constants and types shared by the engine start/stop sequencer files
`default_nettype none
package ess_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_PERIOD_NS = 1000000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Register index; byte address is four times the index
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_TIM0 = 3'h1;
  localparam logic [2:0] IDX_TIM1 = 3'h2;
  localparam logic [2:0] IDX_TIM2 = 3'h3;
  localparam logic [2:0] IDX_TH0 = 3'h4;
  localparam logic [2:0] IDX_TH1 = 3'h5;
  localparam logic [2:0] IDX_STAT = 3'h6;
  localparam logic [2:0] IDX_NONE = 3'h7;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_METHOD_BIT = 1;
  localparam int CTRL_CHARGE_BIT = 2;
  localparam int CTRL_OIL_BIT = 3;
  localparam int CTRL_STARTS_LSB = 4;
  localparam int TIM0_WARM_LSB = 0;
  localparam int TIM0_WAIT_LSB = 8;
  localparam int TIM0_CHOKE_LSB = 16;
  localparam int TIM0_GAS_LSB = 24;
  localparam int TIM1_RIDLE_LSB = 0;
  localparam int TIM1_SIDLE_LSB = 8;
  localparam int TIM1_CRANK_LSB = 16;
  localparam int TIM1_HOLD_LSB = 24;
  localparam int TIM2_COOL_LSB = 0;
  localparam int TIM2_STOP_LSB = 16;
  localparam int TIM2_OIL_LSB = 24;
  localparam int TH0_VCUT_LSB = 0;
  localparam int TH0_RPMCUT_LSB = 16;
  localparam int TH1_FCUT_LSB = 0;
  localparam int TH1_CHGCUT_LSB = 8;
  localparam int TH1_WTEMP_LSB = 16;
  localparam int TH1_OILLIM_LSB = 24;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ATT_LSB = 4;
  localparam int STAT_WARN_BIT = 8;
  localparam int STAT_SFAIL_BIT = 9;
  localparam int STAT_LOAD_BIT = 10;
  localparam int STAT_CHK_BIT = 11;
  localparam int STAT_OUT_LSB = 16;

  localparam logic [7:0] WARM_DEF = 8'h04;
  localparam logic [7:0] WAIT_DEF = 8'h0a;
  localparam logic [7:0] CHOKE_DEF = 8'h05;
  localparam logic [7:0] GAS_DEF = 8'h05;
  localparam logic [7:0] RIDLE_DEF = 8'h00;
  localparam logic [7:0] SIDLE_DEF = 8'h00;
  localparam logic [3:0] CRANK_DEF = 4'h6;
  localparam logic [4:0] HOLD_DEF = 5'h0a;
  localparam logic [9:0] COOL_DEF = 10'h078;
  localparam logic [6:0] STOP_DEF = 7'h0a;
  localparam logic [4:0] OILD_DEF = 5'h02;
  localparam logic [15:0] VCUT_DEF = 16'h0064;
  localparam logic [15:0] RPMCUT_DEF = 16'h01f4;
  localparam logic [7:0] FCUT_DEF = 8'h0a;
  localparam logic [7:0] CHGCUT_DEF = 8'h06;
  localparam logic [7:0] WTEMP_DEF = 8'h00;
  localparam logic [7:0] OILLIM_DEF = 8'h00;
  localparam logic [2:0] STARTS_DEF = 3'h3;
  localparam logic [2:0] STARTS_MIN = 3'h1;
  localparam logic [2:0] STARTS_MAX = 3'h6;

  localparam logic [31:0] CTRL_RST = {25'h0, STARTS_DEF, 4'h0};
  localparam logic [31:0] TIM0_RST = {GAS_DEF, CHOKE_DEF, WAIT_DEF, WARM_DEF};
  localparam logic [31:0] TIM1_RST = {3'h0, HOLD_DEF, 4'h0, CRANK_DEF, SIDLE_DEF, RIDLE_DEF};
  localparam logic [31:0] TIM2_RST = {3'h0, OILD_DEF, 1'h0, STOP_DEF, 6'h0, COOL_DEF};
  localparam logic [31:0] TH0_RST = {RPMCUT_DEF, VCUT_DEF};
  localparam logic [31:0] TH1_RST = {OILLIM_DEF, WTEMP_DEF, CHGCUT_DEF, FCUT_DEF};
  localparam logic [31:0] CTRL_MASK = 32'h0000007f;
  localparam logic [31:0] TIM1_MASK = 32'h1f0fffff;
  localparam logic [31:0] TIM2_MASK = 32'h1f7f03ff;

  typedef enum logic [3:0] {
    st_off, st_crank, st_wait, st_run_idle, st_warm,
    st_loaded, st_cool, st_stop_idle, st_stop, st_fail
  } ess_seq_t;
endpackage
`default_nettype wire

// [hw/ess_pin_sync.sv]
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
`default_nettype none
module ess_pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] o;
  } ess_sync_t;

  ess_sync_t q;
  ess_sync_t d;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("ess_pin_sync: WIDTH must be at least one");
    end
  endgenerate

  // Only stages two and three are compared; stage one feeds stage two alone
  always_comb
  begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.o = (q.s2 & q.s3) | (q.o & (q.s2 ^ q.s3));
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else
      q <= d;
  end

  assign pin_out = q.o;
endmodule
`default_nettype wire

// [hw/ess_sec_tick.sv]
// One-second tick generator from the system clock
`timescale 1ns/10ps
`default_nettype none
module ess_sec_tick #(
  parameter int unsigned CYCLES = ess_pkg::TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick
);
  localparam int unsigned CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } ess_tick_t;

  ess_tick_t q;
  ess_tick_t d;

  generate
    if (CYCLES < 2)
    begin : g_chk
      $error("ess_sec_tick: CYCLES must be at least two");
    end
  endgenerate

  always_comb
  begin
    d = q;
    d.tick = (q.cnt == LAST);
    d.cnt = d.tick ? '0 : q.cnt + CW'(1);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else
      q <= d;
  end

  assign tick = q.tick;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_tick_single: assert property (tick |=> !tick)
    else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire

// [hw/ess_sequencer.sv]
// Engine start/stop sequencer with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module ess_sequencer #(
  parameter int unsigned TICK_CYCLES = ess_pkg::TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic run_req,
  input wire logic oil_switch_open,
  input wire logic [15:0] gen_volt_l1,
  input wire logic [7:0] gen_freq,
  input wire logic [15:0] engine_rpm,
  input wire logic [7:0] charge_volt,
  input wire logic [7:0] oil_press,
  input wire logic [7:0] coolant_temp,
  output logic crank_out,
  output logic choke_out,
  output logic gas_out,
  output logic idle_out,
  output logic stop_out,
  output logic load_permit,
  output logic low_checks_enable,
  output logic shutdown_failure_warning,
  output logic start_failure
);
  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [2:0] wr_idx;
    logic [31:0] ctrl;
    logic [31:0] tim0;
    logic [31:0] tim1;
    logic [31:0] tim2;
    logic [31:0] th0;
    logic [31:0] th1;
    ess_pkg::ess_seq_t st;
    logic [9:0] tmr;
    logic [7:0] choke_cnt;
    logic [7:0] gas_cnt;
    logic [4:0] oil_cnt;
    logic [4:0] hold_cnt;
    logic [2:0] attempts;
    logic crank;
    logic choke;
    logic gas;
    logic idle;
    logic stop;
    logic load;
    logic chk;
    logic warn;
    logic sfail;
  } ess_main_t;

  localparam ess_main_t Q_RST = '{
    hreadyout: 1'b1,
    ctrl: ess_pkg::CTRL_RST,
    tim0: ess_pkg::TIM0_RST,
    tim1: ess_pkg::TIM1_RST,
    tim2: ess_pkg::TIM2_RST,
    th0: ess_pkg::TH0_RST,
    th1: ess_pkg::TH1_RST,
    st: ess_pkg::st_off,
    default: '0
  };

  ess_main_t q;
  ess_main_t d;

  logic tick;
  logic [1:0] pins;
  logic run;
  logic [7:0] t_warm, t_wait, t_choke, t_gas, t_ridle, t_sidle;
  logic [3:0] t_crank;
  logic [4:0] t_hold, t_oil;
  logic [9:0] t_cool;
  logic [6:0] t_stop;
  logic [15:0] v_cut, rpm_cut;
  logic [7:0] f_cut, chg_cut, warm_temp, oil_lim;
  logic [2:0] starts, starts_eff;
  logic cut_volt, cut_freq, cut_rpm, cut_chg, oil_cond, oil_cut, crank_cut;
  logic still_running, expired, sel_ok, clr_warn, set_warn, go_crank;

  function automatic logic [2:0] reg_index(input logic [31:0] addr);
    reg_index = ess_pkg::IDX_NONE;
    if (addr[31:5] == 27'h0 && addr[1:0] == 2'h0 && addr[4:2] <= ess_pkg::IDX_STAT)
      reg_index = addr[4:2];
  endfunction

  function automatic logic is_running(input ess_pkg::ess_seq_t st);
    is_running = (st == ess_pkg::st_run_idle) || (st == ess_pkg::st_warm) ||
                 (st == ess_pkg::st_loaded) || (st == ess_pkg::st_cool) ||
                 (st == ess_pkg::st_stop_idle);
  endfunction

  function automatic logic [31:0] read_word(input logic [2:0] idx, input ess_main_t s);
    read_word = 32'h0;
    case (idx)
      ess_pkg::IDX_CTRL: read_word = s.ctrl;
      ess_pkg::IDX_TIM0: read_word = s.tim0;
      ess_pkg::IDX_TIM1: read_word = s.tim1;
      ess_pkg::IDX_TIM2: read_word = s.tim2;
      ess_pkg::IDX_TH0: read_word = s.th0;
      ess_pkg::IDX_TH1: read_word = s.th1;
      ess_pkg::IDX_STAT:
      begin
        read_word[ess_pkg::STAT_STATE_LSB +: 4] = s.st;
        read_word[ess_pkg::STAT_ATT_LSB +: 3] = s.attempts;
        read_word[ess_pkg::STAT_WARN_BIT] = s.warn;
        read_word[ess_pkg::STAT_SFAIL_BIT] = s.sfail;
        read_word[ess_pkg::STAT_LOAD_BIT] = s.load;
        read_word[ess_pkg::STAT_CHK_BIT] = s.chk;
        read_word[ess_pkg::STAT_OUT_LSB +: 5] = {s.stop, s.idle, s.gas, s.choke, s.crank};
      end
      default: read_word = 32'h0;
    endcase
  endfunction

  ess_sec_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  ess_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in({oil_switch_open, run_req}),
    .pin_out(pins)
  );

  assign run = pins[0] | q.ctrl[ess_pkg::CTRL_RUN_BIT];
  assign t_warm = q.tim0[ess_pkg::TIM0_WARM_LSB +: 8];
  assign t_wait = q.tim0[ess_pkg::TIM0_WAIT_LSB +: 8];
  assign t_choke = q.tim0[ess_pkg::TIM0_CHOKE_LSB +: 8];
  assign t_gas = q.tim0[ess_pkg::TIM0_GAS_LSB +: 8];
  assign t_ridle = q.tim1[ess_pkg::TIM1_RIDLE_LSB +: 8];
  assign t_sidle = q.tim1[ess_pkg::TIM1_SIDLE_LSB +: 8];
  assign t_crank = q.tim1[ess_pkg::TIM1_CRANK_LSB +: 4];
  assign t_hold = q.tim1[ess_pkg::TIM1_HOLD_LSB +: 5];
  assign t_cool = q.tim2[ess_pkg::TIM2_COOL_LSB +: 10];
  assign t_stop = q.tim2[ess_pkg::TIM2_STOP_LSB +: 7];
  assign t_oil = q.tim2[ess_pkg::TIM2_OIL_LSB +: 5];
  assign v_cut = q.th0[ess_pkg::TH0_VCUT_LSB +: 16];
  assign rpm_cut = q.th0[ess_pkg::TH0_RPMCUT_LSB +: 16];
  assign f_cut = q.th1[ess_pkg::TH1_FCUT_LSB +: 8];
  assign chg_cut = q.th1[ess_pkg::TH1_CHGCUT_LSB +: 8];
  assign warm_temp = q.th1[ess_pkg::TH1_WTEMP_LSB +: 8];
  assign oil_lim = q.th1[ess_pkg::TH1_OILLIM_LSB +: 8];

  // Out-of-range attempt counts are clamped so a bad write cannot lock cranking out
  assign starts = q.ctrl[ess_pkg::CTRL_STARTS_LSB +: 3];
  assign starts_eff = (starts < ess_pkg::STARTS_MIN) ? ess_pkg::STARTS_MIN :
                      (starts > ess_pkg::STARTS_MAX) ? ess_pkg::STARTS_MAX : starts;

  assign cut_volt = gen_volt_l1 >= v_cut;
  assign cut_freq = gen_freq >= f_cut;
  assign cut_rpm = engine_rpm >= rpm_cut;
  assign cut_chg = q.ctrl[ess_pkg::CTRL_CHARGE_BIT] && (charge_volt >= chg_cut);
  assign oil_cond = q.ctrl[ess_pkg::CTRL_OIL_BIT] && (pins[1] || (oil_press > oil_lim));
  assign oil_cut = oil_cond && (q.oil_cnt == 5'h0);
  assign crank_cut = cut_volt | cut_freq | cut_rpm | cut_chg | oil_cut;
  assign still_running = cut_volt | cut_freq | cut_rpm;
  assign expired = (q.tmr == 10'h0);
  assign sel_ok = hsel && htrans[1] && hready;
  assign clr_warn = q.wr_pend && (q.wr_idx == ess_pkg::IDX_STAT) && hwdata[ess_pkg::STAT_WARN_BIT];
  assign set_warn = (q.st == ess_pkg::st_stop) && expired && still_running;

  always_comb
  begin
    d = q;
    go_crank = 1'b0;
    d.hreadyout = 1'b1;
    d.hresp = 1'b0;
    if (q.wr_pend)
    begin
      case (q.wr_idx)
        ess_pkg::IDX_CTRL: d.ctrl = hwdata & ess_pkg::CTRL_MASK;
        ess_pkg::IDX_TIM0: d.tim0 = hwdata;
        ess_pkg::IDX_TIM1: d.tim1 = hwdata & ess_pkg::TIM1_MASK;
        ess_pkg::IDX_TIM2: d.tim2 = hwdata & ess_pkg::TIM2_MASK;
        ess_pkg::IDX_TH0: d.th0 = hwdata;
        ess_pkg::IDX_TH1: d.th1 = hwdata;
        default: d.ctrl = q.ctrl;
      endcase
    end
    d.wr_pend = sel_ok && hwrite;
    d.wr_idx = reg_index(haddr);

    d.tmr = (tick && q.tmr != 10'h0) ? q.tmr - 10'h1 : q.tmr;
    case (q.st)
      ess_pkg::st_off:
      begin
        d.attempts = 3'h0;
        go_crank = run;
      end
      ess_pkg::st_crank:
      begin
        if (tick && q.choke_cnt != 8'h0)
          d.choke_cnt = q.choke_cnt - 8'h1;
        if (tick && q.gas_cnt != 8'h0)
          d.gas_cnt = q.gas_cnt - 8'h1;
        if (!oil_cond)
          d.oil_cnt = t_oil;
        else if (tick && q.oil_cnt != 5'h0)
          d.oil_cnt = q.oil_cnt - 5'h1;
        if (!run)
        begin
          d.st = ess_pkg::st_stop;
          d.tmr = {3'h0, t_stop};
        end
        else if (crank_cut)
        begin
          d.st = ess_pkg::st_run_idle;
          d.tmr = {2'h0, t_ridle};
        end
        else if (expired)
        begin
          d.attempts = q.attempts + 3'h1;
          if (q.attempts + 3'h1 >= starts_eff)
            d.st = ess_pkg::st_fail;
          else
          begin
            d.st = ess_pkg::st_wait;
            d.tmr = {2'h0, t_wait};
          end
        end
      end
      ess_pkg::st_wait:
      begin
        if (!run)
          d.st = ess_pkg::st_off;
        else if (expired)
        begin
          if (q.attempts >= starts_eff)
            d.st = ess_pkg::st_fail;
          else
            go_crank = 1'b1;
        end
      end
      ess_pkg::st_run_idle:
      begin
        if (!run)
        begin
          d.st = ess_pkg::st_stop_idle;
          d.tmr = {2'h0, t_sidle};
        end
        else if (expired)
        begin
          d.st = ess_pkg::st_warm;
          d.tmr = {2'h0, t_warm};
        end
      end
      ess_pkg::st_warm:
      begin
        if (!run)
        begin
          d.st = ess_pkg::st_stop_idle;
          d.tmr = {2'h0, t_sidle};
        end
        else if (expired && (!q.ctrl[ess_pkg::CTRL_METHOD_BIT] || coolant_temp >= warm_temp))
          d.st = ess_pkg::st_loaded;
      end
      ess_pkg::st_loaded:
      begin
        if (!run)
        begin
          d.st = ess_pkg::st_cool;
          d.tmr = t_cool;
        end
      end
      ess_pkg::st_cool:
      begin
        if (run)
          d.st = ess_pkg::st_loaded;
        else if (expired)
        begin
          d.st = ess_pkg::st_stop_idle;
          d.tmr = {2'h0, t_sidle};
        end
      end
      ess_pkg::st_stop_idle:
      begin
        if (expired)
        begin
          d.st = ess_pkg::st_stop;
          d.tmr = {3'h0, t_stop};
        end
      end
      ess_pkg::st_stop:
      begin
        if (expired)
          d.st = ess_pkg::st_off;
      end
      ess_pkg::st_fail:
      begin
        if (!run)
          d.st = ess_pkg::st_off;
      end
      default: d.st = ess_pkg::st_off;
    endcase
    if (go_crank)
    begin
      d.st = ess_pkg::st_crank;
      d.tmr = {6'h0, t_crank};
      d.choke_cnt = t_choke;
      d.gas_cnt = t_gas;
      d.oil_cnt = t_oil;
    end

    // Crank, choke, idle and stop drop on the count reaching zero, so a zero setting never pulses them
    d.crank = (d.st == ess_pkg::st_crank) && (d.tmr != 10'h0);
    d.choke = d.crank && (d.choke_cnt != 8'h0);
    d.gas = (d.crank && d.gas_cnt == 8'h0) || is_running(d.st);
    d.idle = ((d.st == ess_pkg::st_run_idle) || (d.st == ess_pkg::st_stop_idle)) &&
             (d.tmr != 10'h0);
    d.stop = (d.st == ess_pkg::st_stop) && (d.tmr != 10'h0);
    d.load = (d.st == ess_pkg::st_loaded);
    // Reload until idle has left the register, so the tick that ends idle cannot eat the holdoff
    if (d.idle || q.idle)
      d.hold_cnt = t_hold;
    else if (tick && q.hold_cnt != 5'h0)
      d.hold_cnt = q.hold_cnt - 5'h1;
    d.chk = is_running(d.st) && !d.idle && (q.hold_cnt == 5'h0);
    d.warn = (q.warn && !clr_warn) || set_warn;
    d.sfail = (d.st == ess_pkg::st_fail);

    // Read data come from the post-write copy so a write then read sees the new value
    if (sel_ok && !hwrite)
      d.hrdata = read_word(reg_index(haddr), d);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= Q_RST;
    else
      q <= d;
  end

  assign hreadyout = q.hreadyout;
  assign hresp = q.hresp;
  assign hrdata = q.hrdata;
  assign crank_out = q.crank;
  assign choke_out = q.choke;
  assign gas_out = q.gas;
  assign idle_out = q.idle;
  assign stop_out = q.stop;
  assign load_permit = q.load;
  assign low_checks_enable = q.chk;
  assign shutdown_failure_warning = q.warn;
  assign start_failure = q.sfail;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_load_after_warm: assert property ($rose(load_permit) |->
    ($past(q.st) == ess_pkg::st_warm) || ($past(q.st) == ess_pkg::st_cool))
    else $error("load permission without finished warm-up");
  a_warm_temp_gate: assert property ((q.st == ess_pkg::st_loaded) &&
    ($past(q.st) == ess_pkg::st_warm) && $past(q.ctrl[ess_pkg::CTRL_METHOD_BIT]) |->
    ($past(coolant_temp) >= $past(warm_temp)))
    else $error("load taken before coolant reached warm-up temperature");
  a_stop_bound: assert property (stop_out |->
    (q.st == ess_pkg::st_stop) && (q.tmr != 10'h0))
    else $error("stop relay energised outside the stop period");
  a_fail_warn: assert property (set_warn |=> shutdown_failure_warning)
    else $error("stop failure not flagged");
  a_choke_with_crank: assert property (choke_out |-> crank_out)
    else $error("choke active without crank");
  a_idle_mask: assert property (idle_out |-> !low_checks_enable)
    else $error("low checks enabled while idle active");
  a_holdoff_wait: assert property ($fell(idle_out) && (t_hold != 5'h0) |->
    !low_checks_enable [*2])
    else $error("low checks enabled before holdoff");
  a_gas_delay: assert property (crank_out && gas_out |-> (q.gas_cnt == 8'h0))
    else $error("gas opened before its delay");
  a_cut_volt: assert property (crank_out && cut_volt |=> !crank_out)
    else $error("crank held after voltage cut");
  a_cut_freq: assert property (crank_out && cut_freq |=> !crank_out)
    else $error("crank held after frequency cut");
  a_cut_rpm: assert property (crank_out && cut_rpm |=> !crank_out)
    else $error("crank held after speed cut");
  a_cut_charge: assert property (crank_out && cut_chg |=> !crank_out)
    else $error("crank held after charge cut");
  a_attempt_limit: assert property (crank_out |-> (q.attempts < starts_eff))
    else $error("crank attempt beyond programmed number");
  a_cut_runs: assert property (crank_out && crank_cut && run |=>
    (q.st == ess_pkg::st_run_idle))
    else $error("crank cut did not lead to running");
endmodule
`default_nettype wire

// [dv/ess_engine_model.sv]
// Engine and genset measurements answering the sequencer relays
`timescale 1ns/10ps
`default_nettype none
module ess_engine_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic crank_out,
  input wire logic stop_out,
  input wire logic fire_en,
  input wire logic stuck,
  output logic [15:0] rpm,
  output logic [15:0] volt,
  output logic [7:0] freq
);
  logic running_q;
  // A stuck engine ignores the stop relay, which lets the bench provoke a failed stop
  // Once freed, cutting the fuel enable stops it as well
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      running_q <= 1'b0;
    else if (crank_out && fire_en)
      running_q <= 1'b1;
    else if (!stuck && (stop_out || !fire_en))
      running_q <= 1'b0;
  assign rpm = running_q ? 16'h05dc : 16'h0000;
  assign volt = running_q ? 16'h00e6 : 16'h0000;
  assign freq = running_q ? 8'h32 : 8'h00;
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the start/stop sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, run_req, fire, stuck;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] rpm, volt;
  logic [7:0] freq, charge_volt, coolant;
  logic [8:0] outs;
  logic crank, choke, gas, idle, stp, permit, chk_en, warn, sfail, hresp;
  int mismatches, compares;
  logic [31:0] rst_tab [7] = '{32'h30, 32'h05050a04, 32'h0a060000, 32'h020a0078,
    32'h01f40064, 32'h0000060a, 32'h0};
  assign outs = {sfail, warn, chk_en, permit, stp, idle, gas, choke, crank};
  ess_sequencer #(.TICK_CYCLES(20)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .run_req(run_req),
    .oil_switch_open(1'b0), .gen_volt_l1(volt), .gen_freq(freq), .engine_rpm(rpm),
    .charge_volt(charge_volt), .oil_press(8'h00), .coolant_temp(coolant), .crank_out(crank),
    .choke_out(choke), .gas_out(gas), .idle_out(idle), .stop_out(stp), .load_permit(permit),
    .low_checks_enable(chk_en), .shutdown_failure_warning(warn), .start_failure(sfail));
  ess_engine_model eng_u (.hclk(hclk), .hresetn(hresetn), .crank_out(crank), .stop_out(stp),
    .fire_en(fire), .stuck(stuck), .rpm(rpm), .volt(volt), .freq(freq));
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic s);
    chk32(n, {31'h0, e}, {31'h0, s});
  endtask
  // Zero wait states are promised, yet the master still waits on hready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic waitv(input int b, input logic v, input string n);
    int i;
    i = 0;
    while (outs[b] !== v && i < 4000)
    begin
      @(posedge hclk);
      i++;
    end
    chk1(n, v, outs[b]);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial
  begin
    #(5 * 40000);
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    {hresetn, hsel, hwrite, run_req, fire, stuck} = 6'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    charge_volt = 8'h08;
    coolant = 8'h00;
    mismatches = 0;
    compares = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      xfer(1'b0, 32'(i * 4), 32'h0);
      chk32("reset value", rst_tab[i], rd);
      chk32("bus answer", 32'h1, {30'h0, hresp, hready});
    end
    xfer(1'b1, 32'h04, 32'h01030102);
    xfer(1'b1, 32'h08, 32'h01020201);
    xfer(1'b1, 32'h0c, 32'h02020001);
    xfer(1'b1, 32'h14, 32'h0028060a);
    xfer(1'b0, 32'h08, 32'h0);
    chk32("timer write", 32'h01020201, rd);
    xfer(1'b1, 32'h00, 32'h00000013);
    waitv(0, 1'b1, "crank on");
    chk1("choke with crank", 1'b1, choke);
    chk1("no load while cranking", 1'b0, permit);
    waitv(2, 1'b1, "gas open");
    chk1("still cranking", 1'b1, crank);
    fire <= 1'b1;
    waitv(0, 1'b0, "crank cut on speed");
    @(posedge hclk);
    chk1("choke released on run", 1'b0, choke);
    chk1("run idle", 1'b1, idle);
    chk1("checks masked", 1'b0, chk_en);
    repeat (80) @(posedge hclk);
    chk1("no load while cold", 1'b0, permit);
    coolant <= 8'h32;
    waitv(5, 1'b1, "load permitted");
    waitv(6, 1'b1, "checks back");
    stuck <= 1'b1;
    xfer(1'b1, 32'h00, 32'h00000010);
    repeat (2) @(posedge hclk);
    chk1("unloaded in cooldown", 1'b0, permit);
    chk1("running in cooldown", 1'b1, gas);
    waitv(3, 1'b1, "stop idle");
    waitv(4, 1'b1, "stop relay");
    waitv(7, 1'b1, "stop failure");
    chk1("stop relay released", 1'b0, stp);
    stuck <= 1'b0;
    fire <= 1'b0;
    xfer(1'b1, 32'h18, 32'h00000100);
    waitv(7, 1'b0, "warning cleared");
    waitv(4, 1'b0, "stopped");
    run_req <= 1'b1;
    waitv(0, 1'b1, "crank from pin");
    waitv(8, 1'b1, "attempts used");
    chk1("no crank after fail", 1'b0, crank);
    run_req <= 1'b0;
    waitv(8, 1'b0, "fail left");
    xfer(1'b1, 32'h00, 32'h00000014);
    coolant <= 8'h00;
    run_req <= 1'b1;
    waitv(0, 1'b1, "crank again");
    waitv(0, 1'b0, "crank cut on charge");
    chk1("cut counts as running", 1'b1, gas);
    waitv(5, 1'b1, "load on timer alone");
    run_req <= 1'b0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
